//--- rpsm_defines.svh
`ifndef RPSM_DEFINES_SVH
`define RPSM_DEFINES_SVH

`define RPSM_ADR_W          8
`define RPSM_FIELD_W        5
`define RPSM_PIN_COUNT      26
`define RPSM_OUT_PINS       6
`define RPSM_FUNC_COUNT     32
`define RPSM_REG_W          16
`define RPSM_REG_COUNT      8

// Register indices; byte address is index times four
`define RPSM_IDX_W          3
`define RPSM_IDX_SPI_A_CD   3'h0
`define RPSM_IDX_SPI_A_SEL  3'h1
`define RPSM_IDX_SPI_B_CD   3'h2
`define RPSM_IDX_SPI_B_SEL  3'h3
`define RPSM_IDX_CAN_RX     3'h4
`define RPSM_IDX_OUT_01     3'h5
`define RPSM_IDX_OUT_23     3'h6
`define RPSM_IDX_OUT_45     3'h7

`define RPSM_ADR_IDX_HI     4
`define RPSM_ADR_IDX_LO     2
`define RPSM_ADR_TOP_HI     7
`define RPSM_ADR_TOP_LO     5
`define RPSM_ADR_TOP_ZERO   3'h0

// Field positions
`define RPSM_UPPER_HI       12
`define RPSM_UPPER_LO       8
`define RPSM_LOWER_HI       4
`define RPSM_LOWER_LO       0

// Implemented-bit masks and reset values
`define RPSM_MASK_TWO       16'h1F1F
`define RPSM_MASK_ONE       16'h001F
`define RPSM_RST_IN_TWO     16'h1F1F
`define RPSM_RST_IN_ONE     16'h001F
`define RPSM_RST_OUT        16'h0000

`define RPSM_CODE_GROUND    5'h1F
`define RPSM_CODE_MAX_PIN   5'h19
`define RPSM_CODE_NONE      5'h00

`define RPSM_LANE0_MASK     16'h00FF
`define RPSM_LANE1_MASK     16'hFF00

`endif

//--- rpsm_pkg.sv
package rpsm_pkg;

  // Peripheral inputs fed through the input selectors
  typedef struct packed {
    logic spi_a_clock_input;
    logic spi_a_data_input;
    logic spi_a_select_input;
    logic spi_b_clock_input;
    logic spi_b_data_input;
    logic spi_b_select_input;
    logic can_receive_input;
  } rpsm_route_type;

  // Drive for remappable pins 0 to 5
  typedef struct packed {
    logic [5:0] value;
    logic [5:0] enable;
  } rpsm_pin_drive_type;

  // Classic Wishbone request
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [1:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } rpsm_wb_req_type;

endpackage

//--- rpsm_top.sv
// Local design decisions: register access over Wishbone and the address map.
`timescale 1ns/1ps
`include "rpsm_defines.svh"

module rpsm_top
  import rpsm_pkg::*;
#(
  parameter bit CAN_PRESENT = 1'b1
)
(
  input  wire logic                         i_mclk,
  input  wire logic                         i_rst,
  input  wire rpsm_wb_req_type              i_wb,
  output logic                              o_wb_ack,
  output logic [31:0]                       o_wb_dat,
  input  wire logic [`RPSM_PIN_COUNT-1:0]   i_remappable_pin,
  input  wire logic [`RPSM_FUNC_COUNT-1:0]  i_periph_func,
  output rpsm_route_type                    o_route,
  output rpsm_pin_drive_type                o_pin_drive
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [`RPSM_REG_W-1:0] impl_mask
    (input logic [`RPSM_IDX_W-1:0] idx);
    case (idx)
      `RPSM_IDX_SPI_A_SEL,
      `RPSM_IDX_SPI_B_SEL,
      `RPSM_IDX_CAN_RX:     impl_mask = `RPSM_MASK_ONE;
      default:              impl_mask = `RPSM_MASK_TWO;
    endcase
  endfunction

  function automatic logic [`RPSM_REG_W-1:0] reset_value
    (input logic [`RPSM_IDX_W-1:0] idx);
    case (idx)
      `RPSM_IDX_SPI_A_CD,
      `RPSM_IDX_SPI_B_CD:   reset_value = `RPSM_RST_IN_TWO;
      `RPSM_IDX_SPI_A_SEL,
      `RPSM_IDX_SPI_B_SEL,
      `RPSM_IDX_CAN_RX:     reset_value = `RPSM_RST_IN_ONE;
      default:              reset_value = `RPSM_RST_OUT;
    endcase
  endfunction

  // Codes 26..30 are undefined; they ground the input like code 31
  function automatic logic pick_pin
    (input logic [`RPSM_FIELD_W-1:0]  code,
     input logic [`RPSM_PIN_COUNT-1:0] pins);
    if (code <= `RPSM_CODE_MAX_PIN)
    begin
      pick_pin = pins[code];
    end
    else
    begin
      pick_pin = 1'b0;
    end
  endfunction

  function automatic logic [`RPSM_FIELD_W-1:0] upper_field
    (input logic [`RPSM_REG_W-1:0] r);
    upper_field = r[`RPSM_UPPER_HI:`RPSM_UPPER_LO];
  endfunction

  function automatic logic [`RPSM_FIELD_W-1:0] lower_field
    (input logic [`RPSM_REG_W-1:0] r);
    lower_field = r[`RPSM_LOWER_HI:`RPSM_LOWER_LO];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic [`RPSM_REG_W-1:0]  sel_reg [0:`RPSM_REG_COUNT-1];
  logic                    bus_req;
  logic                    mapped;
  logic [`RPSM_IDX_W-1:0]  idx;
  logic [`RPSM_REG_W-1:0]  lane_mask;
  logic                    reg_live;

  assign bus_req = i_wb.cyc & i_wb.stb & ~o_wb_ack;
  assign idx     = i_wb.adr[`RPSM_ADR_IDX_HI:`RPSM_ADR_IDX_LO];
  assign mapped  = (i_wb.adr[`RPSM_ADR_TOP_HI:`RPSM_ADR_TOP_LO]
                    == `RPSM_ADR_TOP_ZERO);
  // Without a CAN controller its selector is absent from the map
  assign reg_live = mapped
                    & ((idx != `RPSM_IDX_CAN_RX) | CAN_PRESENT);
  assign lane_mask = ({`RPSM_REG_W{i_wb.sel[0]}} & `RPSM_LANE0_MASK)
                   | ({`RPSM_REG_W{i_wb.sel[1]}} & `RPSM_LANE1_MASK);

  // One wait state: ack rises the edge after the request and drops next
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_wb_ack <= 1'b0;
    end
    else
    begin
      o_wb_ack <= bus_req;
    end
  end

  // Read data is registered with the ack; unmapped reads answer zero
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_wb_dat <= 32'h00000000;
    end
    else if (bus_req & ~i_wb.we & reg_live)
    begin
      o_wb_dat <= {16'h0000, sel_reg[idx] & impl_mask(idx)};
    end
    else
    begin
      o_wb_dat <= 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Selector registers

  // Write lands on the acking edge, so the master sees it complete there
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      for (int i = 0; i < `RPSM_REG_COUNT; i++)
      begin
        sel_reg[i] <= reset_value(i[`RPSM_IDX_W-1:0]);
      end
    end
    else if (bus_req & i_wb.we & reg_live)
    begin
      sel_reg[idx] <= ((sel_reg[idx] & ~lane_mask)
                      | (i_wb.dat[`RPSM_REG_W-1:0] & lane_mask))
                      & impl_mask(idx);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin input synchroniser: three stages, accept when last two agree

  logic [`RPSM_PIN_COUNT-1:0] pin_s1;
  logic [`RPSM_PIN_COUNT-1:0] pin_s2;
  logic [`RPSM_PIN_COUNT-1:0] pin_s3;
  logic [`RPSM_PIN_COUNT-1:0] pin_level;

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      pin_s1    <= '0;
      pin_s2    <= '0;
      pin_s3    <= '0;
      pin_level <= '0;
    end
    else
    begin
      pin_s1 <= i_remappable_pin;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      for (int i = 0; i < `RPSM_PIN_COUNT; i++)
      begin
        if (pin_s2[i] == pin_s3[i])
        begin
          pin_level[i] <= pin_s3[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input routing

  rpsm_route_type next_route;

  always_comb
  begin
    next_route.spi_a_clock_input =
      pick_pin(upper_field(sel_reg[`RPSM_IDX_SPI_A_CD]), pin_level);
    next_route.spi_a_data_input =
      pick_pin(lower_field(sel_reg[`RPSM_IDX_SPI_A_CD]), pin_level);
    next_route.spi_a_select_input =
      pick_pin(lower_field(sel_reg[`RPSM_IDX_SPI_A_SEL]), pin_level);
    next_route.spi_b_clock_input =
      pick_pin(upper_field(sel_reg[`RPSM_IDX_SPI_B_CD]), pin_level);
    next_route.spi_b_data_input =
      pick_pin(lower_field(sel_reg[`RPSM_IDX_SPI_B_CD]), pin_level);
    next_route.spi_b_select_input =
      pick_pin(lower_field(sel_reg[`RPSM_IDX_SPI_B_SEL]), pin_level);
    next_route.can_receive_input = CAN_PRESENT
      & pick_pin(lower_field(sel_reg[`RPSM_IDX_CAN_RX]), pin_level);
  end

  // Registered: routing follows a write one edge after the acking edge
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_route <= '0;
    end
    else
    begin
      o_route <= next_route;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output function select

  rpsm_pin_drive_type          next_drive;
  logic [`RPSM_FIELD_W-1:0]    out_code [0:`RPSM_OUT_PINS-1];

  always_comb
  begin
    for (int p = 0; p < `RPSM_OUT_PINS; p++)
    begin
      // Even pin in lower field, odd pin in upper field
      if (p[0])
      begin
        out_code[p] = upper_field(sel_reg[`RPSM_IDX_OUT_01 + (p >> 1)]);
      end
      else
      begin
        out_code[p] = lower_field(sel_reg[`RPSM_IDX_OUT_01 + (p >> 1)]);
      end
    end
  end

  always_comb
  begin
    next_drive = '0;
    for (int p = 0; p < `RPSM_OUT_PINS; p++)
    begin
      if (out_code[p] != `RPSM_CODE_NONE)
      begin
        next_drive.enable[p] = 1'b1;
        next_drive.value[p]  = i_periph_func[out_code[p]];
      end
      else
      begin
        next_drive.enable[p] = 1'b0;
        next_drive.value[p]  = 1'b0;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_pin_drive <= '0;
    end
    else
    begin
      o_pin_drive <= next_drive;
    end
  end

endmodule

//--- rpsm_chk.sv
`timescale 1ns/1ps
`include "rpsm_defines.svh"

module rpsm_chk
  import rpsm_pkg::*;
(
  input wire logic                      i_mclk,
  input wire logic                      i_rst,
  input wire rpsm_wb_req_type           i_wb,
  input wire logic                      o_wb_ack,
  input wire logic [31:0]               o_wb_dat,
  input wire logic [`RPSM_PIN_COUNT-1:0] i_remappable_pin,
  input wire logic [31:0]               i_periph_func,
  input wire rpsm_route_type            o_route,
  input wire rpsm_pin_drive_type        o_pin_drive
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  ////////////////////////////////////////////////////////////////////////
  sequence s_req;
    i_wb.cyc && i_wb.stb && !o_wb_ack;
  endsequence
  sequence s_pin0(bit on);
    s_req ##0 (i_wb.we && i_wb.adr == 8'h14 && i_wb.sel[0]
      && ((i_wb.dat[4:0] != 5'h00) == on)) ##1 o_wb_ack;
  endsequence

  ////////////////////////////////////////////////////////////////////////
  a_ack_follows_req: assert property (s_req |=> o_wb_ack)
    else $error("ack missing after request");
  a_ack_one_pulse: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  a_ack_has_cause: assert property (o_wb_ack |-> $past(i_wb.stb))
    else $error("ack without request");
  a_dat_idle_zero: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
    else $error("read data not zero outside ack");
  a_dat_unimpl_zero: assert property (
    o_wb_ack |-> (o_wb_dat & ~32'h00001F1F) == 32'h0)
    else $error("unimplemented bits not zero");
  a_unmapped_zero: assert property (
    s_req ##0 (!i_wb.we && i_wb.adr[7:5] != 3'h0) |=> o_wb_dat == 32'h0)
    else $error("unmapped read not zero");
  a_reset_state: assert property (
    $fell(i_rst) |-> o_route == '0 && o_pin_drive == '0)
    else $error("outputs not at reset state");
  a_pin_applies: assert property (
    s_pin0(1) |=> o_pin_drive.enable[0])
    else $error("pin 0 not enabled after write");
  a_pin_releases: assert property (
    s_pin0(0) |=> !o_pin_drive.enable[0])
    else $error("pin 0 still enabled by code 0");
  a_enable_cause: assert property (
    $changed(o_pin_drive.enable) |-> $past(o_wb_ack))
    else $error("pin enable moved without a write");
endmodule

bind rpsm_top rpsm_chk i_rpsm_chk (.i_mclk(i_mclk), .i_rst(i_rst),
  .i_wb(i_wb),
  .o_wb_ack(o_wb_ack), .o_wb_dat(o_wb_dat),
  .i_remappable_pin(i_remappable_pin), .i_periph_func(i_periph_func),
  .o_route(o_route), .o_pin_drive(o_pin_drive));

//--- rpsm_top_tb.sv
`timescale 1ns/1ps
`include "rpsm_defines.svh"

module rpsm_top_tb
  import rpsm_pkg::*;
;
  logic               i_mclk;
  logic               i_rst;
  rpsm_wb_req_type    i_wb;
  logic               o_wb_ack;
  logic [31:0]        o_wb_dat;
  logic [25:0]        pins;
  logic [31:0]        funcs;
  rpsm_route_type     o_route;
  rpsm_pin_drive_type o_pin_drive;
  logic [31:0]        q;
  logic [31:0]        q_nc;
  logic [31:0]        dat_nc;
  logic [31:0]        er;
  rpsm_route_type     route_nc;
  int                 mismatches;
  int                 samples_checked;
  localparam logic [15:0] RST [8] = '{16'h1F1F, 16'h001F, 16'h1F1F,
    16'h001F, 16'h001F, 16'h0000, 16'h0000, 16'h0000};
  localparam logic [15:0] MSK [8] = '{16'h1F1F, 16'h001F, 16'h1F1F,
    16'h001F, 16'h001F, 16'h1F1F, 16'h1F1F, 16'h1F1F};
  localparam logic [7:0] RADR [7] = '{8'h00, 8'h00, 8'h04, 8'h08, 8'h08,
    8'h0C, 8'h10};
  localparam int RSH [7] = '{8, 0, 0, 8, 0, 0, 0};
  localparam int RPIN [7] = '{0, 25, 3, 7, 11, 19, 22};

  rpsm_top #(.CAN_PRESENT(1'b1)) i_rpsm_top (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_wb(i_wb), .o_wb_ack(o_wb_ack), .o_wb_dat(o_wb_dat),
    .i_remappable_pin(pins), .i_periph_func(funcs), .o_route(o_route),
    .o_pin_drive(o_pin_drive));

  // Variant without the CAN controller shares every input
  rpsm_top #(.CAN_PRESENT(1'b0)) i_rpsm_top_nocan (.i_mclk(i_mclk),
    .i_rst(i_rst), .i_wb(i_wb), .o_wb_ack(), .o_wb_dat(dat_nc),
    .i_remappable_pin(pins), .i_periph_func(funcs), .o_route(route_nc),
    .o_pin_drive());

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Read data is taken at the same edge that samples ack high
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [15:0] d, input logic [1:0] s);
    int n;
    n = 0;
    @(posedge i_mclk);
    i_wb <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: s, adr: a, dat: 32'(d)};
    do
    begin
      @(posedge i_mclk);
      n++;
    end
    while (o_wb_ack !== 1'b1);
    q = o_wb_dat;
    q_nc = dat_nc;
    chk("ack latency", 32'(n), 32'h2);
    i_wb <= '0;
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end

  initial
  begin
    repeat (20000) @(posedge i_mclk);
    mismatches++;
    end_sim();
  end

  initial
  begin
    i_rst = 1'b1;
    i_wb = '0;
    pins = '0;
    funcs = '0;
    repeat (10) @(posedge i_mclk);
    i_rst <= 1'b0;
    for (int r = 0; r < 8; r++)
    begin
      bus(1'b0, 8'(r * 4), 16'h0000, 2'b11);
      chk("reset value", q, 32'(RST[r]));
      chk("no can reset", q_nc, (r == 4) ? 32'h0 : 32'(RST[r]));
      bus(1'b1, 8'(r * 4), 16'hFFFF, 2'b11);
      bus(1'b0, 8'(r * 4), 16'h0000, 2'b11);
      chk("write mask", q, 32'(MSK[r]));
      chk("no can mask", q_nc, (r == 4) ? 32'h0 : 32'(MSK[r]));
      bus(1'b1, 8'(r * 4), RST[r], 2'b11);
    end
    for (int k = 0; k < 7; k++)
    begin
      bus(1'b1, RADR[k], 16'(RPIN[k] << RSH[k]), RSH[k] ? 2'b10 : 2'b01);
      pins <= 26'h1 << RPIN[k];
      repeat (8) @(posedge i_mclk);
      er = 32'h40 >> k;
      chk("route", 32'(o_route), er);
      chk("no can route", 32'(route_nc), (k == 6) ? 32'h0 : er);
      pins <= ~(26'h1 << RPIN[k]);
      repeat (8) @(posedge i_mclk);
      chk("route low", 32'(o_route), 32'h0);
      bus(1'b1, RADR[k], 16'(16'h1F << RSH[k]), RSH[k] ? 2'b10 : 2'b01);
      pins <= '1;
      repeat (8) @(posedge i_mclk);
      chk("ground", 32'(o_route), 32'h0);
    end
    for (int j = 0; j < 6; j++)
    begin
      bus(1'b1, 8'(8'h14 + 4 * (j / 2)), 16'((j + 1) << (8 * (j % 2))),
          (j % 2) ? 2'b10 : 2'b01);
      funcs <= 32'h1 << (j + 1);
      @(posedge i_mclk);
      chk("enable", 32'(o_pin_drive.enable), (32'h2 << j) - 1);
      @(posedge i_mclk);
      chk("drive", 32'(o_pin_drive.value), 32'h1 << j);
    end
    bus(1'b1, 8'h14, 16'h0000, 2'b01);
    @(posedge i_mclk);
    chk("code zero", 32'(o_pin_drive.enable), 32'h3E);
    bus(1'b1, 8'h20, 16'hFFFF, 2'b11);
    bus(1'b0, 8'h20, 16'h0000, 2'b11);
    chk("unmapped", q, 32'h0);
    bus(1'b0, 8'h00, 16'h0000, 2'b11);
    chk("no alias", q, 32'h1F1F);
    // Second reset after the selectors have been moved off their defaults
    bus(1'b1, 8'h00, 16'h0102, 2'b11);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_mclk);
    i_rst <= 1'b0;
    bus(1'b0, 8'h00, 16'h0000, 2'b11);
    chk("reset again", q, 32'h1F1F);
    bus(1'b0, 8'h18, 16'h0000, 2'b11);
    chk("reset out", q, 32'h0);
    chk("reset drive", 32'(o_pin_drive.enable), 32'h0);
    end_sim();
  end
endmodule
